/* File: src/blkwr_pkg.sv */
// shared constants for the block-write command decoder
package blkwr_pkg;
    localparam int FRAME_BITS = 48;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] FRAME_LAST = 6'h2f;
    // frame bit positions, first bit on the line is bit 47
    localparam int POS_START = 47;
    localparam int POS_DIR = 46;
    localparam int POS_IDX_HI = 45;
    localparam int POS_IDX_LO = 40;
    localparam int POS_ARG_HI = 39;
    localparam int POS_ARG_LO = 8;
    localparam int POS_END = 0;
    // command indices
    localparam logic [5:0] CMD_STOP = 6'h0c;
    localparam logic [5:0] CMD_READ_MULTI = 6'h12;
    localparam logic [5:0] CMD_SET_COUNT = 6'h17;
    localparam logic [5:0] CMD_WRITE_ONE = 6'h18;
    localparam logic [5:0] CMD_WRITE_MULTI = 6'h19;
    localparam logic [5:0] CMD_PROG_ID = 6'h1a;
    localparam logic [5:0] CMD_PROG_SPECIFIC = 6'h1b;
    // block count field of the set-count argument
    localparam int COUNT_HI = 15;
    localparam int COUNT_LO = 0;
    localparam int COUNT_W = 16;
    localparam int REG_W = 128;
    localparam logic [REG_W-1:0] ID_RESET = 128'h0;
    localparam logic [REG_W-1:0] SPEC_RESET = 128'h0;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SINGLE,
        ST_MULTI,
        ST_PROG_ID,
        ST_PROG_SPEC
    } wr_state_t;
endpackage : blkwr_pkg

/* File: src/cmd_frame_if.sv */
// carrier for decoded command frames between receiver and decoder
`timescale 1ns/1ps
`default_nettype none
interface cmd_frame_if;
    logic valid;
    logic [5:0] index;
    logic [31:0] arg;
    modport rx (output valid, output index, output arg);
    modport dec (input valid, input index, input arg);
endinterface : cmd_frame_if
`default_nettype wire

/* File: src/cmd_frame_rx.sv */
// samples the bus clock and command pin, assembles 48-bit command frames
`timescale 1ns/1ps
`default_nettype none
module cmd_frame_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_clk,
    input wire logic cmd_pin,
    cmd_frame_if.rx frm
);
    logic [2:0] bclk_r;
    logic [1:0] cmd_sync_r;
    logic busy_r;
    logic [blkwr_pkg::CNT_W-1:0] cnt_r;
    logic [blkwr_pkg::FRAME_BITS-1:0] sh_r;
    logic valid_r;
    logic [5:0] index_r;
    logic [31:0] arg_r;
    wire rise = bclk_r[1] & ~bclk_r[2];
    wire bit_in = cmd_sync_r[1];
    wire [blkwr_pkg::FRAME_BITS-1:0] sh_nxt = {sh_r[blkwr_pkg::FRAME_BITS-2:0], bit_in};
    wire last_bit = busy_r && (cnt_r == blkwr_pkg::FRAME_LAST);
    // host always drives transmitter bit high; frames failing framing are dropped
    wire frame_ok = sh_nxt[blkwr_pkg::POS_DIR] && sh_nxt[blkwr_pkg::POS_END]
                    && !sh_nxt[blkwr_pkg::POS_START];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bclk_r <= 3'h0;
            cmd_sync_r <= 2'h3;
        end else begin
            bclk_r <= {bclk_r[1:0], bus_clk};
            cmd_sync_r <= {cmd_sync_r[0], cmd_pin};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
            sh_r <= '0;
        end else if (rise) begin
            sh_r <= sh_nxt;
            if (!busy_r) begin
                busy_r <= !bit_in;
                cnt_r <= 6'h1;
            end else if (last_bit) begin
                busy_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r + 6'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            index_r <= 6'h0;
            arg_r <= 32'h0;
        end else begin
            valid_r <= rise && last_bit && frame_ok;
            if (rise && last_bit) begin
                index_r <= sh_nxt[blkwr_pkg::POS_IDX_HI:blkwr_pkg::POS_IDX_LO];
                arg_r <= sh_nxt[blkwr_pkg::POS_ARG_HI:blkwr_pkg::POS_ARG_LO];
            end
        end
    end

    assign frm.valid = valid_r;
    assign frm.index = index_r;
    assign frm.arg = arg_r;
endmodule : cmd_frame_rx
`default_nettype wire

/* File: src/card_block_write_cmd_decode.sv */
// card-side decoder for the block-write command group
// Behaviour
// RULE1: set-count command stores a block count for the next multi-block command.
// RULE2: host sends zero in upper sixteen bits, count in lower sixteen.
// RULE3: single write moves exactly one block of the selected block length.
// RULE4: both write commands take the full 32-bit argument as start address.
// RULE5: multi-block write takes blocks continuously until stop-transmission.
// RULE6: identification register programs once; later attempts are refused. Here the lock clears on reset, so it can be programmed again after a reset.
// RULE7: host should not program the identification register in normal use.
// RULE8: specific-data programming changes only programmable bits.
// RULE9: crossing a physical block boundary is an error unless misalignment allowed.
// RULE10: nonzero preset count ends multi-block write by itself after that many blocks.
`timescale 1ns/1ps
`default_nettype none
module card_block_write_cmd_decode #(
    parameter int PHYS_LOG2 = 9,
    parameter int MISALIGN_BIT = 78,
    parameter logic [127:0] SPEC_PROG_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_ff00
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic BUS_CLK,
    input wire logic CMD_IN,
    input wire logic [11:0] BLOCK_LEN,
    input wire logic BLK_DONE,
    input wire logic [127:0] BLK_DATA,
    output logic CMD_ACCEPT,
    output logic CMD_REFUSE,
    output logic ADDR_ERR,
    output logic XFER_END,
    output logic WR_BUSY,
    output logic WR_MULTI,
    output logic [31:0] WR_ADDR,
    output logic [15:0] BLK_LEFT,
    output logic COUNT_ARMED,
    output logic ID_LOCKED,
    output logic [127:0] ID_REG,
    output logic [127:0] SPEC_REG
);
    cmd_frame_if frm ();

    cmd_frame_rx u_rx (
        .clk(CLK),
        .rst_n(RST_N),
        .bus_clk(BUS_CLK),
        .cmd_pin(CMD_IN),
        .frm(frm)
    );

    blkwr_pkg::wr_state_t state_r, state_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [15:0] count_r, count_nxt;
    logic armed_r, armed_nxt;
    logic limited_r, limited_nxt;
    logic [15:0] left_r, left_nxt;
    logic id_locked_r, id_locked_nxt;
    logic [127:0] id_r, id_nxt;
    logic [127:0] spec_r, spec_nxt;
    logic accept_nxt, refuse_nxt, aerr_nxt, end_nxt;
    logic accept_r, refuse_r, aerr_r, end_r;

    // command decode
    wire new_cmd = frm.valid;
    wire is_stop = new_cmd && (frm.index == blkwr_pkg::CMD_STOP);
    wire is_count = new_cmd && (frm.index == blkwr_pkg::CMD_SET_COUNT);
    wire is_one = new_cmd && (frm.index == blkwr_pkg::CMD_WRITE_ONE);
    wire is_multi = new_cmd && (frm.index == blkwr_pkg::CMD_WRITE_MULTI);
    wire is_rd_multi = new_cmd && (frm.index == blkwr_pkg::CMD_READ_MULTI);
    wire is_prog_id = new_cmd && (frm.index == blkwr_pkg::CMD_PROG_ID);
    wire is_prog_spec = new_cmd && (frm.index == blkwr_pkg::CMD_PROG_SPECIFIC);
    wire [15:0] arg_count = frm.arg[blkwr_pkg::COUNT_HI:blkwr_pkg::COUNT_LO]; // RULE2

    // boundary check for a block of BLOCK_LEN bytes starting at a given address
    wire misalign_ok = spec_r[MISALIGN_BIT];
    wire [12:0] phys_size = 13'(1 << PHYS_LOG2);
    wire [12:0] start_off = 13'(frm.arg[PHYS_LOG2-1:0]);
    wire [31:0] addr_nxt_blk = addr_r + 32'(BLOCK_LEN);
    wire [12:0] next_addr_off = 13'(addr_nxt_blk[PHYS_LOG2-1:0]);
    wire start_cross = (start_off + 13'(BLOCK_LEN)) > phys_size; // RULE9
    wire next_cross = (next_addr_off + 13'(BLOCK_LEN)) > phys_size; // RULE9
    wire start_bad = start_cross && !misalign_ok;
    wire next_bad = next_cross && !misalign_ok;
    // programmable bits come from the block, read-only bits stay put
    wire [127:0] spec_merge = (spec_r & ~SPEC_PROG_MASK) | (BLK_DATA & SPEC_PROG_MASK); // RULE8
    wire idle = (state_r == blkwr_pkg::ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        count_nxt = count_r;
        armed_nxt = armed_r;
        limited_nxt = limited_r;
        left_nxt = left_r;
        id_locked_nxt = id_locked_r;
        id_nxt = id_r;
        spec_nxt = spec_r;
        accept_nxt = 1'b0;
        refuse_nxt = 1'b0;
        aerr_nxt = 1'b0;
        end_nxt = 1'b0;
        // a preset count only holds for the very next command
        if (new_cmd && !is_count && !is_multi) begin
            armed_nxt = 1'b0; // RULE1
        end
        case (state_r)
            blkwr_pkg::ST_IDLE: begin
                if (is_count) begin
                    count_nxt = arg_count; // RULE1
                    armed_nxt = 1'b1; // RULE1
                    accept_nxt = 1'b1;
                end else if (is_one || is_multi) begin
                    addr_nxt = frm.arg; // RULE4
                    if (is_multi) begin
                        armed_nxt = 1'b0;
                        limited_nxt = armed_r && (count_r != 16'h0); // RULE10
                        // unlimited transfers show zero so nothing counts down
                        left_nxt = limited_nxt ? count_r : 16'h0; // RULE10
                    end
                    if (start_bad) begin
                        aerr_nxt = 1'b1; // RULE9
                        refuse_nxt = 1'b1;
                    end else begin
                        accept_nxt = 1'b1;
                        state_nxt = is_one ? blkwr_pkg::ST_SINGLE : blkwr_pkg::ST_MULTI;
                    end
                end else if (is_prog_id) begin
                    // one-time only, the lock clears only on reset
                    if (id_locked_r) begin
                        refuse_nxt = 1'b1; // RULE6
                    end else begin
                        accept_nxt = 1'b1;
                        state_nxt = blkwr_pkg::ST_PROG_ID;
                    end
                end else if (is_prog_spec) begin
                    accept_nxt = 1'b1;
                    state_nxt = blkwr_pkg::ST_PROG_SPEC;
                end else if (is_rd_multi) begin
                    armed_nxt = 1'b0;
                end
            end
            blkwr_pkg::ST_SINGLE: begin
                if (BLK_DONE) begin
                    end_nxt = 1'b1; // RULE3
                    state_nxt = blkwr_pkg::ST_IDLE;
                end
            end
            blkwr_pkg::ST_MULTI: begin
                if (is_stop) begin
                    end_nxt = 1'b1; // RULE5
                    state_nxt = blkwr_pkg::ST_IDLE;
                end else if (BLK_DONE) begin
                    addr_nxt = addr_nxt_blk; // RULE5
                    if (limited_r) begin
                        left_nxt = left_r - 16'h1;
                    end
                    if (limited_r && (left_r == 16'h1)) begin
                        end_nxt = 1'b1; // RULE10
                        state_nxt = blkwr_pkg::ST_IDLE;
                    end else if (next_bad) begin
                        aerr_nxt = 1'b1; // RULE9
                        end_nxt = 1'b1;
                        state_nxt = blkwr_pkg::ST_IDLE;
                    end
                end
            end
            blkwr_pkg::ST_PROG_ID: begin
                if (BLK_DONE) begin
                    id_nxt = BLK_DATA;
                    id_locked_nxt = 1'b1; // RULE6
                    end_nxt = 1'b1;
                    state_nxt = blkwr_pkg::ST_IDLE;
                end
            end
            blkwr_pkg::ST_PROG_SPEC: begin
                if (BLK_DONE) begin
                    spec_nxt = spec_merge; // RULE8
                    end_nxt = 1'b1;
                    state_nxt = blkwr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = blkwr_pkg::ST_IDLE;
            end
        endcase
        // commands arriving while a transfer runs, other than stop during a multi-block write, are refused
        if (new_cmd && !idle && !(is_stop && state_r == blkwr_pkg::ST_MULTI)) begin
            refuse_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= blkwr_pkg::ST_IDLE;
            addr_r <= 32'h0;
            count_r <= 16'h0;
            armed_r <= 1'b0;
            limited_r <= 1'b0;
            left_r <= 16'h0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            count_r <= count_nxt;
            armed_r <= armed_nxt;
            limited_r <= limited_nxt;
            left_r <= left_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            id_locked_r <= 1'b0;
            id_r <= blkwr_pkg::ID_RESET;
            spec_r <= blkwr_pkg::SPEC_RESET;
        end else begin
            id_locked_r <= id_locked_nxt;
            id_r <= id_nxt;
            spec_r <= spec_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            accept_r <= 1'b0;
            refuse_r <= 1'b0;
            aerr_r <= 1'b0;
            end_r <= 1'b0;
        end else begin
            accept_r <= accept_nxt;
            refuse_r <= refuse_nxt;
            aerr_r <= aerr_nxt;
            end_r <= end_nxt;
        end
    end

    assign CMD_ACCEPT = accept_r;
    assign CMD_REFUSE = refuse_r;
    assign ADDR_ERR = aerr_r;
    assign XFER_END = end_r;
    assign WR_BUSY = !idle;
    assign WR_MULTI = (state_r == blkwr_pkg::ST_MULTI);
    assign WR_ADDR = addr_r;
    assign BLK_LEFT = left_r;
    assign COUNT_ARMED = armed_r;
    assign ID_LOCKED = id_locked_r;
    assign ID_REG = id_r;
    assign SPEC_REG = spec_r;
endmodule : card_block_write_cmd_decode
`default_nettype wire

/* File: testbench/blkwr_checker.sv */
// port-level assertions for the block-write command decoder
`timescale 1ns/1ps
`default_nettype none
module blkwr_checker #(
    parameter logic [127:0] SPEC_PROG_MASK = 128'h0
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [11:0] BLOCK_LEN,
    input wire logic BLK_DONE,
    input wire logic CMD_ACCEPT,
    input wire logic CMD_REFUSE,
    input wire logic ADDR_ERR,
    input wire logic XFER_END,
    input wire logic WR_BUSY,
    input wire logic WR_MULTI,
    input wire logic [31:0] WR_ADDR,
    input wire logic [15:0] BLK_LEFT,
    input wire logic ID_LOCKED,
    input wire logic [127:0] ID_REG,
    input wire logic [127:0] SPEC_REG
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_lock_sticky; ID_LOCKED |=> ID_LOCKED; endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("id lock dropped");
    property p_id_frozen; ID_LOCKED |=> $stable(ID_REG); endproperty
    a_id_frozen: assert property (p_id_frozen) else $error("locked id changed");
    property p_ro_bits; 1'b1 |=> $stable(SPEC_REG & ~SPEC_PROG_MASK); endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only bit moved");
    property p_single_end;
        WR_BUSY && !WR_MULTI && BLK_DONE |-> ##[1:2] XFER_END;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single op not ended");
    property p_count_dec;
        WR_MULTI && BLK_DONE && BLK_LEFT > 16'h1 |=> BLK_LEFT == $past(BLK_LEFT) - 16'h1;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not stepped");
    property p_count_end; WR_MULTI && BLK_DONE && BLK_LEFT == 16'h1 |-> ##[1:2] XFER_END; endproperty
    a_count_end: assert property (p_count_end) else $error("count end missed");
    property p_addr_step;
        WR_MULTI && BLK_DONE && BLK_LEFT != 16'h1
            |=> WR_ADDR == $past(WR_ADDR) + {20'h0, $past(BLOCK_LEN)};
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not advanced");
    property p_addr_err; ADDR_ERR |-> CMD_REFUSE || XFER_END; endproperty
    a_addr_err: assert property (p_addr_err) else $error("stray address error");
    property p_start; $rose(WR_BUSY) |-> CMD_ACCEPT; endproperty
    a_start: assert property (p_start) else $error("busy without accept");
    c_id_prog: cover property (XFER_END && ID_LOCKED);
    c_cross: cover property (CMD_REFUSE && ADDR_ERR);
    c_last: cover property (WR_MULTI && BLK_DONE && BLK_LEFT == 16'h1);
endmodule : blkwr_checker
bind card_block_write_cmd_decode blkwr_checker #(.SPEC_PROG_MASK(SPEC_PROG_MASK)) blkwr_checker_inst (
    .CLK(CLK), .RST_N(RST_N), .BLOCK_LEN(BLOCK_LEN), .BLK_DONE(BLK_DONE),
    .CMD_ACCEPT(CMD_ACCEPT), .CMD_REFUSE(CMD_REFUSE), .ADDR_ERR(ADDR_ERR),
    .XFER_END(XFER_END), .WR_BUSY(WR_BUSY), .WR_MULTI(WR_MULTI), .WR_ADDR(WR_ADDR),
    .BLK_LEFT(BLK_LEFT), .ID_LOCKED(ID_LOCKED), .ID_REG(ID_REG), .SPEC_REG(SPEC_REG)
);
`default_nettype wire

/* File: testbench/host_cmd_model.sv */
// host side of the command line, bus clock only during frames
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    output var logic BUS_CLK,
    output var logic CMD_IN
);
    initial begin
        BUS_CLK = 1'b0;
        CMD_IN = 1'b1;
    end
    // bit changes while clock low, so it is steady 40 ns round each rise
    task automatic send_frame(input logic [5:0] idx, input logic [31:0] arg,
                              input logic [6:0] crc);
        logic [47:0] f;
        f = {2'b01, idx, arg, crc, 1'b1};
        for (int i = 47; i >= 0; i--) begin
            CMD_IN = f[i];
            #40 BUS_CLK = 1'b1;
            #40 BUS_CLK = 1'b0;
        end
        CMD_IN = 1'b1;
    endtask : send_frame
endmodule : host_cmd_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the block-write command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [1:0] acc = 2'h0, rfs = 2'h1, aer = 2'h2, fin = 2'h3;
    // misalignment bit made writable so both boundary cases are reachable
    localparam logic [127:0] prog_mask = (128'h1 << 78) | 128'hff00;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic blk_done = 1'b0;
    logic [127:0] blk_data = 128'h0;
    logic [11:0] blk_len = 12'h200;
    logic bus_clk, cmd_in, cmd_accept, cmd_refuse, addr_err, xfer_end;
    logic wr_busy, wr_multi, count_armed, id_locked;
    logic [31:0] wr_addr;
    logic [15:0] blk_left;
    logic [127:0] id_reg, spec_reg, d;
    logic [3:0] ev;
    logic [1:0] exp_q[$];
    logic [31:0] rnd = 32'd15489;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    assign ev = {xfer_end, addr_err, cmd_refuse, cmd_accept};
    always #2.5 clk = ~clk;
    host_cmd_model host_cmd_model_inst (.BUS_CLK(bus_clk), .CMD_IN(cmd_in));
    card_block_write_cmd_decode #(.SPEC_PROG_MASK(prog_mask)) card_block_write_cmd_decode_inst (
        .CLK(clk), .RST_N(rst_n), .BUS_CLK(bus_clk), .CMD_IN(cmd_in), .BLOCK_LEN(blk_len),
        .BLK_DONE(blk_done), .BLK_DATA(blk_data), .CMD_ACCEPT(cmd_accept),
        .CMD_REFUSE(cmd_refuse), .ADDR_ERR(addr_err), .XFER_END(xfer_end), .WR_BUSY(wr_busy),
        .WR_MULTI(wr_multi), .WR_ADDR(wr_addr), .BLK_LEFT(blk_left), .COUNT_ARMED(count_armed),
        .ID_LOCKED(id_locked), .ID_REG(id_reg), .SPEC_REG(spec_reg)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // each pulse takes the oldest note; an empty queue reads as code 7
    always @(negedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            chk(128'h0, 128'h1);
            tally_and_finish();
        end
        for (int k = 0; k < 4; k++) begin
            if (rst_n && ev[k] === 1'b1) begin
                chk(128'(k), (exp_q.size() != 0) ? 128'(exp_q.pop_front()) : 128'h7);
            end
        end
    end
    task automatic settle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk(128'(exp_q.size()), 128'h0);
        exp_q.delete();
        repeat (3) @(negedge clk);
    endtask : settle
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [3:0] evs,
                       input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(evs[2*i+:2]);
        rnd = xs(rnd);
        host_cmd_model_inst.send_frame(idx, arg, rnd[6:0]);
        settle();
    endtask : cmd
    task automatic blocks(input int n, input logic [127:0] dat, input int ends);
        if (ends != 0) exp_q.push_back(fin);
        @(negedge clk);
        blk_done = 1'b1;
        blk_data = dat;
        repeat (n) @(negedge clk);
        blk_done = 1'b0;
        settle();
    endtask : blocks
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(128'({wr_busy, count_armed, id_locked}), 128'h0);
        chk(id_reg | spec_reg, 128'h0);
        $display("test reset done");
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h400, {2'h0, acc}, 1);
        chk(128'({wr_busy, wr_multi, wr_addr}), 128'({2'b10, 32'h400}));
        blocks(1, 128'h0, 1);
        chk(128'(wr_busy), 128'h0);
        cmd(blkwr_pkg::CMD_SET_COUNT, {16'h0, 16'h2}, {2'h0, acc}, 1);
        chk(128'(count_armed), 128'h1);
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h0, {2'h0, acc}, 1);
        chk(128'(count_armed), 128'h0);
        blocks(1, 128'h0, 1);
        cmd(blkwr_pkg::CMD_SET_COUNT, {16'h0, 16'h2}, {2'h0, acc}, 1);
        cmd(blkwr_pkg::CMD_READ_MULTI, 32'h0, 4'h0, 0);
        chk(128'({count_armed, wr_busy}), 128'h0);
        $display("test single write done");
        cmd(blkwr_pkg::CMD_SET_COUNT, {16'h0, 16'h3}, {2'h0, acc}, 1);
        cmd(blkwr_pkg::CMD_WRITE_MULTI, 32'h200, {2'h0, acc}, 1);
        chk(128'({wr_multi, count_armed, blk_left}), 128'({2'b10, 16'h3}));
        blocks(2, 128'h0, 0);
        chk(128'({wr_addr, blk_left, wr_busy}), 128'({32'h600, 16'h1, 1'b1}));
        blocks(1, 128'h0, 1);
        chk(128'(wr_busy), 128'h0);
        $display("test counted multi done");
        cmd(blkwr_pkg::CMD_WRITE_MULTI, 32'h0, {2'h0, acc}, 1);
        blocks(5, 128'h0, 0);
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h0, {2'h0, rfs}, 1);
        chk(128'({wr_busy, wr_multi, wr_addr}), 128'({2'b11, 32'ha00}));
        cmd(blkwr_pkg::CMD_STOP, 32'h0, {2'h0, fin}, 1);
        chk(128'(wr_busy), 128'h0);
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h100, {aer, rfs}, 2);
        // shorter blocks: same start fits, a later block crosses mid-transfer
        blk_len = 12'h100;
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h100, {2'h0, acc}, 1);
        blocks(1, 128'h0, 1);
        cmd(blkwr_pkg::CMD_WRITE_MULTI, 32'h80, {2'h0, acc}, 1);
        exp_q.push_back(aer);
        blocks(1, 128'h0, 1);
        chk(128'({wr_busy, wr_addr}), 128'({1'b0, 32'h180}));
        blk_len = 12'h200;
        $display("test stop and boundary done");
        rnd = xs(rnd);
        d = {4{rnd}};
        cmd(blkwr_pkg::CMD_PROG_ID, rnd, {2'h0, acc}, 1);
        blocks(1, d, 1);
        chk(id_reg, d);
        cmd(blkwr_pkg::CMD_PROG_ID, 32'h0, {2'h0, rfs}, 1);
        blocks(1, ~d, 0);
        chk(id_reg, d);
        chk(128'(id_locked), 128'h1);
        d = ~d | (128'h1 << 78);
        cmd(blkwr_pkg::CMD_PROG_SPECIFIC, 32'h0, {2'h0, acc}, 1);
        blocks(1, d, 1);
        chk(spec_reg, d & prog_mask);
        cmd(blkwr_pkg::CMD_WRITE_ONE, 32'h100, {2'h0, acc}, 1);
        blocks(1, 128'h0, 1);
        $display("test programming done");
        // lock is volatile: a reset clears it along with the registers
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(128'({id_locked, count_armed, wr_busy}), 128'h0);
        chk(spec_reg, 128'h0);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
